/* eig_consts.svh */
/*
 * Constants for the enclave instruction gate: register indices, field
 * positions, leaf numbers and exception codes.
 * Assumes it is included once per compilation unit by bare name.
 */
`ifndef EIG_CONSTS_SVH
`define EIG_CONSTS_SVH

// ==========================================================
// register indices (word address)
`define EIG_REG_FEAT_LO      4'h0
`define EIG_REG_FEAT_HI      4'h1
`define EIG_REG_BMAP_LO      4'h2
`define EIG_REG_BMAP_HI      4'h3
`define EIG_REG_VMCTL        4'h4
`define EIG_REG_CAPS         4'h5
`define EIG_REG_STATUS       4'h6
`define EIG_REG_KEY0         4'h8
`define EIG_KEY_WORDS        8

// ==========================================================
// feature control fields
`define EIG_FC_LOCK          0
`define EIG_FC_LAUNCH_KEY_WRITE_ENABLE         17
`define EIG_FC_EN            18
`define EIG_FEAT_RESET       32'h0000_0000

// ==========================================================
// leaf numbers and exception codes
`define EIG_LEAF_DBG_RD      6'h04
`define EIG_LEAF_DBG_WR      6'h05
`define EIG_LEAF_ENTER       6'h02
`define EIG_LEAF_RESUME      6'h03
`define EIG_LEAF_EXIT        6'h04
`define EIG_EXC_NONE         3'h0
`define EIG_EXC_UD           3'h1
`define EIG_EXC_GP0          3'h2
`define EIG_EXC_VMEXIT       3'h3

`endif

/* eig_pkg.sv */
/*
 * Types for the enclave instruction gate.
 * Assumes eig_consts.svh is compiled alongside.
 */
package eig_pkg;
    typedef struct packed {
        logic [31:0] base;
        logic [31:0] limit;
        logic [7:0]  attr;
    } eig_seg_s;

    typedef enum logic [1:0] {
        EIG_ST_OUT,
        EIG_ST_IN
    } eig_mode_e;
endpackage

/* eig_seg_if.sv */
/*
 * Carrier for the thread-local segment pair between the gate and its
 * save/restore store.
 * Assumes a single core clock.
 */
`timescale 1ns/10ps
interface eig_seg_if;
    eig_pkg::eig_seg_s seg_a_in;
    eig_pkg::eig_seg_s seg_b_in;
    logic              save;
    logic              restore;
    eig_pkg::eig_seg_s seg_a_saved;
    eig_pkg::eig_seg_s seg_b_saved;
    modport gate  (output seg_a_in, output seg_b_in, output save, output restore,
                   input seg_a_saved, input seg_b_saved);
    modport store (input seg_a_in, input seg_b_in, input save, input restore,
                   output seg_a_saved, output seg_b_saved);
endinterface

/* eig_seg_store.sv */
/*
 * Holds the outside-enclave thread-local segment pair across an enclave
 * stay, hidden parts included.
 * Assumes save and restore never fire together.
 */
`timescale 1ns/10ps
module eig_seg_store (
    input  wire logic REF_CLK,  // core clock
    input  wire logic RST,      // async reset
    eig_seg_if.store  sif       // segment carrier
);
    typedef struct packed {
        eig_pkg::eig_seg_s a;
        eig_pkg::eig_seg_s b;
    } eig_store_s;

    eig_store_s st;
    eig_store_s next_st;

    always_comb begin
        next_st = st;
        if (sif.save) begin
            next_st.a = sif.seg_a_in;
            next_st.b = sif.seg_b_in;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sif.seg_a_saved = st.a;
    assign sif.seg_b_saved = st.b;
endmodule

/* eig_gate.sv */
/*
 * Enclave instruction gate: decides per attempted enclave instruction
 * whether it raises #UD, #GP(0), a guest exit, or proceeds; manages the
 * thread-local segment swap on entry and exit; owns the feature control,
 * exit bitmap and launch key hash registers.
 * Assumes core state inputs are synchronous to REF_CLK and an instruction
 * request is a one-cycle pulse.
 */
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "eig_consts.svh"

module eig_gate (
    input  wire logic        REF_CLK,        // core clock, 100 MHz
    input  wire logic        RST,            // async reset, active high
    input  wire logic [3:0]  REG_ADDR,       // register word index
    input  wire logic [31:0] REG_WDATA,      // register write data
    input  wire logic        REG_WR,         // write strobe
    input  wire logic        REG_RD,         // read strobe
    output logic      [31:0] REG_RDATA,      // read data, next cycle
    input  wire logic        PROT_MODE,      // protected mode
    input  wire logic        SMM_MODE,       // system management mode
    input  wire logic        V86_MODE,       // virtual-8086 mode
    input  wire logic        PAGING_EN,      // paging enable bit
    input  wire logic        LONG_MODE,      // 64-bit mode
    input  wire logic        GUEST_MODE,     // running as guest
    input  wire logic [1:0]  PRIV_LEVEL,     // current privilege level
    input  wire logic        CAP_LEAF_SET1,  // first leaf collection supported
    input  wire logic        CAP_LAUNCH,     // launch control supported
    input  wire logic        INSN_VALID,     // enclave instruction attempt
    input  wire logic        INSN_SUPER,     // supervisor (1) or user (0)
    input  wire logic [5:0]  INSN_LEAF,      // leaf number
    input  wire logic        PFX_OPSIZE,     // operand-size prefix present
    input  wire logic        DS_USABLE,      // data segment usable
    input  wire logic        DS_EXP_DOWN,    // data segment expand-down
    input  wire logic [31:0] DS_BASE,        // data segment base
    input  wire logic [31:0] DS_LIMIT,       // data segment limit
    input  wire logic [7:0]  DS_ATTR,        // data segment rights
    input  wire logic        OTHER_BASE_NZ,  // some usable other segment base nonzero
    input  wire logic        ENCL_MODE64,    // enclave wide mode attribute
    input  wire logic [31:0] ENCL_BASE,      // enclave base address
    input  wire logic [31:0] SEG_A_OFS,      // thread seg a offset
    input  wire logic [31:0] SEG_A_LIM,      // thread seg a limit
    input  wire logic [31:0] SEG_B_OFS,      // thread seg b offset
    input  wire logic [31:0] SEG_B_LIM,      // thread seg b limit
    input  wire eig_pkg::eig_seg_s CUR_SEG_A,  // live thread seg a
    input  wire eig_pkg::eig_seg_s CUR_SEG_B,  // live thread seg b
    input  wire logic        ASYNC_EXIT,     // asynchronous exit event
    input  wire logic        SEG_WRITE_INSN, // segment-modifying insn in enclave
    input  wire logic        BASE_WR_INSN,   // thread base write insn
    input  wire logic        BASE_WR_SEL,    // 0 seg a, 1 seg b
    input  wire logic [31:0] BASE_WR_DATA,   // new base value
    output logic             DONE,           // verdict pulse
    output logic [2:0]       EXC_CODE,       // verdict code
    output logic             ADDR_WIDE,      // operand address width 64
    output logic             IN_ENCLAVE,     // inside enclave
    output logic             SEG_LOAD,       // pulse: load SEG_A/SEG_B
    output eig_pkg::eig_seg_s SEG_A,         // thread seg a to load
    output eig_pkg::eig_seg_s SEG_B,         // thread seg b to load
    output logic             AVAILABLE,      // extensions available
    output logic             KEY_PRESENT     // key hash regs implemented
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [31:0]       feat;
        logic [63:0]       bmap;
        logic              exit_ctl;
        logic [`EIG_KEY_WORDS-1:0][31:0] key;
        logic [31:0]       rdata;
        logic              done;
        logic [2:0]        exc;
        logic              wide;
        eig_pkg::eig_mode_e mode;
        logic              mode64;
        logic              seg_load;
        eig_pkg::eig_seg_s seg_a;
        eig_pkg::eig_seg_s seg_b;
        logic [31:0]       ssa_a;
        logic [31:0]       ssa_b;
        logic              avail;
        logic              keyp;
    } eig_state_s;

    eig_state_s r;
    eig_state_s next_r;

    eig_seg_if sif ();

    eig_seg_store u_store (
        .REF_CLK (REF_CLK),
        .RST     (RST),
        .sif     (sif.store)
    );

    // ==========================================================
    // decode helpers
    function automatic logic fc_locked(input logic [31:0] f);
        return f[`EIG_FC_LOCK];
    endfunction

    function automatic logic seg_inside(input logic [31:0] b, input logic [31:0] l,
                                        input logic [31:0] db, input logic [31:0] dl);
        logic [32:0] top;
        logic [32:0] dtop;
        top  = {1'b0, b} + {1'b0, l};
        dtop = {1'b0, db} + {1'b0, dl};
        return (b >= db) && (top <= dtop);
    endfunction

    logic avail_now;
    logic key_impl;
    logic key_wr_ok;
    logic is_entry;
    logic [31:0] a_base;
    logic [31:0] b_base;
    eig_pkg::eig_seg_s new_a;
    eig_pkg::eig_seg_s new_b;

    always_comb begin
        avail_now = r.feat[`EIG_FC_EN] && fc_locked(r.feat);
        key_impl  = CAP_LEAF_SET1 && CAP_LAUNCH;
        key_wr_ok = key_impl && r.feat[`EIG_FC_LAUNCH_KEY_WRITE_ENABLE] && fc_locked(r.feat);
        is_entry  = !INSN_SUPER && (INSN_LEAF == `EIG_LEAF_ENTER ||
                    INSN_LEAF == `EIG_LEAF_RESUME);
        a_base    = SEG_A_OFS + ENCL_BASE;
        b_base    = SEG_B_OFS + ENCL_BASE;
        new_a     = '{base: a_base, limit: SEG_A_LIM, attr: DS_ATTR};
        new_b     = '{base: b_base, limit: SEG_B_LIM, attr: DS_ATTR};
        // resume brings back bases written inside a 64-bit enclave
        if (INSN_LEAF == `EIG_LEAF_RESUME && ENCL_MODE64) begin
            new_a.base = r.ssa_a;
            new_b.base = r.ssa_b;
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        next_r          = r;
        next_r.done     = 1'b0;
        next_r.seg_load = 1'b0;
        next_r.avail    = avail_now;
        next_r.keyp     = key_impl;
        sif.save        = 1'b0;
        sif.restore     = 1'b0;
        sif.seg_a_in    = CUR_SEG_A;
        sif.seg_b_in    = CUR_SEG_B;

        // register writes; the lock bit freezes feature control
        if (REG_WR) begin
            unique case (REG_ADDR)
                `EIG_REG_FEAT_LO: if (!fc_locked(r.feat)) next_r.feat = REG_WDATA;
                `EIG_REG_BMAP_LO: next_r.bmap[31:0]  = REG_WDATA;
                `EIG_REG_BMAP_HI: next_r.bmap[63:32] = REG_WDATA;
                `EIG_REG_VMCTL:   next_r.exit_ctl    = REG_WDATA[0];
                default: begin
                    if (REG_ADDR >= `EIG_REG_KEY0 && key_wr_ok) begin
                        next_r.key[REG_ADDR[2:0]] = REG_WDATA;
                    end
                end
            endcase
        end
        if (REG_RD) begin
            unique case (REG_ADDR)
                `EIG_REG_FEAT_LO: next_r.rdata = r.feat;
                `EIG_REG_BMAP_LO: next_r.rdata = r.bmap[31:0];
                `EIG_REG_BMAP_HI: next_r.rdata = r.bmap[63:32];
                `EIG_REG_VMCTL:   next_r.rdata = {31'h0, r.exit_ctl};
                // capabilities only; enable bit deliberately absent
                `EIG_REG_CAPS:    next_r.rdata = {30'h0, CAP_LAUNCH, CAP_LEAF_SET1};
                `EIG_REG_STATUS:  next_r.rdata = {29'h0, r.mode64,
                                                  r.mode == eig_pkg::EIG_ST_IN, avail_now};
                default: next_r.rdata = (REG_ADDR >= `EIG_REG_KEY0 && key_impl) ?
                                        r.key[REG_ADDR[2:0]] : 32'h0000_0000;
            endcase
        end

        // inside-enclave events
        if (r.mode == eig_pkg::EIG_ST_IN) begin
            if (SEG_WRITE_INSN) begin
                next_r.done = 1'b1;
                next_r.exc  = `EIG_EXC_UD;
            end
            if (BASE_WR_INSN && r.mode64) begin
                if (BASE_WR_SEL) next_r.ssa_b = BASE_WR_DATA;
                else             next_r.ssa_a = BASE_WR_DATA;
            end else if (BASE_WR_INSN) begin
                next_r.done = 1'b1;
                next_r.exc  = `EIG_EXC_UD;
            end
            if (ASYNC_EXIT) begin
                sif.restore     = 1'b1;
                next_r.seg_a    = sif.seg_a_saved;
                next_r.seg_b    = sif.seg_b_saved;
                next_r.seg_load = 1'b1;
                next_r.mode     = eig_pkg::EIG_ST_OUT;
            end
        end

        // instruction verdict, in fixed order
        if (INSN_VALID) begin
            next_r.done = 1'b1;
            next_r.wide = LONG_MODE;
            // operands are data-segment offsets; override prefix never consulted
            if (!PROT_MODE || SMM_MODE || V86_MODE || !avail_now) begin
                next_r.exc = `EIG_EXC_UD;
            end else if (!PAGING_EN && !(INSN_SUPER &&
                         (INSN_LEAF == `EIG_LEAF_DBG_RD || INSN_LEAF == `EIG_LEAF_DBG_WR))) begin
                next_r.exc = `EIG_EXC_UD;
            end else if (PFX_OPSIZE) begin
                next_r.exc = `EIG_EXC_UD;
            end else if (INSN_SUPER && PRIV_LEVEL != 2'h0) begin
                next_r.exc = `EIG_EXC_GP0;
            end else if (INSN_SUPER && GUEST_MODE && r.exit_ctl && r.bmap[INSN_LEAF]) begin
                next_r.exc = `EIG_EXC_VMEXIT;
            end else if (!DS_USABLE || DS_EXP_DOWN) begin
                next_r.exc = `EIG_EXC_GP0;
            end else if (is_entry) begin
                if (OTHER_BASE_NZ || PRIV_LEVEL != 2'h3 || ENCL_MODE64 != LONG_MODE ||
                    !seg_inside(new_a.base, new_a.limit, DS_BASE, DS_LIMIT) ||
                    !seg_inside(new_b.base, new_b.limit, DS_BASE, DS_LIMIT)) begin
                    next_r.exc = `EIG_EXC_GP0;
                end else begin
                    next_r.exc      = `EIG_EXC_NONE;
                    sif.save        = 1'b1;
                    next_r.seg_a    = new_a;
                    next_r.seg_b    = new_b;
                    next_r.seg_load = 1'b1;
                    next_r.mode     = eig_pkg::EIG_ST_IN;
                    next_r.mode64   = ENCL_MODE64;
                    if (INSN_LEAF == `EIG_LEAF_ENTER) begin
                        next_r.ssa_a = a_base;
                        next_r.ssa_b = b_base;
                    end
                end
            end else if (!INSN_SUPER && INSN_LEAF == `EIG_LEAF_EXIT &&
                         r.mode == eig_pkg::EIG_ST_IN) begin
                next_r.exc      = `EIG_EXC_NONE;
                sif.restore     = 1'b1;
                next_r.seg_a    = sif.seg_a_saved;
                next_r.seg_b    = sif.seg_b_saved;
                next_r.seg_load = 1'b1;
                next_r.mode     = eig_pkg::EIG_ST_OUT;
            end else begin
                // accessed/dirty updates are the pager's, never rolled back
                next_r.exc = `EIG_EXC_NONE;
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            r      <= '0;
            r.feat <= `EIG_FEAT_RESET;
            r.mode <= eig_pkg::EIG_ST_OUT;
        end else begin
            r <= next_r;
        end
    end

    assign REG_RDATA   = r.rdata;
    assign DONE        = r.done;
    assign EXC_CODE    = r.exc;
    assign ADDR_WIDE   = r.wide;
    assign IN_ENCLAVE  = (r.mode == eig_pkg::EIG_ST_IN);
    assign SEG_LOAD    = r.seg_load;
    assign SEG_A       = r.seg_a;
    assign SEG_B       = r.seg_b;
    assign AVAILABLE   = r.avail;
    assign KEY_PRESENT = r.keyp;

    // ==========================================================
    // checks
    unavail_ud_a: assert property (@(posedge REF_CLK) disable iff (RST)
        INSN_VALID && (SMM_MODE || V86_MODE || !PROT_MODE) |=> DONE && EXC_CODE == `EIG_EXC_UD)
        else $error("illegal mode did not raise invalid opcode");
    paging_ud_a: assert property (@(posedge REF_CLK) disable iff (RST)
        INSN_VALID && !INSN_SUPER && !PAGING_EN |=> EXC_CODE == `EIG_EXC_UD)
        else $error("paging off did not raise invalid opcode");
    avail_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)
        AVAILABLE |-> $past(r.feat[`EIG_FC_EN] && r.feat[`EIG_FC_LOCK]))
        else $error("available without enable and lock");
    opsize_ud_a: assert property (@(posedge REF_CLK) disable iff (RST)
        INSN_VALID && PFX_OPSIZE |=> EXC_CODE != `EIG_EXC_NONE)
        else $error("operand-size prefix accepted");
    ds_check_a: assert property (@(posedge REF_CLK) disable iff (RST)
        INSN_VALID && !DS_USABLE |=> EXC_CODE != `EIG_EXC_NONE)
        else $error("unusable data segment accepted");
    segwr_ud_a: assert property (@(posedge REF_CLK) disable iff (RST)
        IN_ENCLAVE && SEG_WRITE_INSN && !INSN_VALID |=> DONE && EXC_CODE == `EIG_EXC_UD)
        else $error("segment write inside enclave not refused");
    bitmap_exit_a: assert property (@(posedge REF_CLK) disable iff (RST)
        INSN_VALID && INSN_SUPER && GUEST_MODE && r.exit_ctl && r.bmap[INSN_LEAF] &&
        PRIV_LEVEL == 2'h0 && PROT_MODE && !SMM_MODE && !V86_MODE && avail_now &&
        PAGING_EN && !PFX_OPSIZE |=> DONE && EXC_CODE == `EIG_EXC_VMEXIT)
        else $error("bitmap exit check broken");
    noexit_off_a: assert property (@(posedge REF_CLK) disable iff (RST)
        INSN_VALID && !r.exit_ctl |=> EXC_CODE != `EIG_EXC_VMEXIT)
        else $error("guest exit with exiting control off");
    priv_first_a: assert property (@(posedge REF_CLK) disable iff (RST)
        INSN_VALID && INSN_SUPER && PRIV_LEVEL != 2'h0 && PROT_MODE && !SMM_MODE &&
        !V86_MODE && avail_now && PAGING_EN && !PFX_OPSIZE |=> EXC_CODE == `EIG_EXC_GP0)
        else $error("bitmap evaluated before privilege check");
endmodule

/* eig_gate_tb.sv */
/* Self-checking bench for eig_gate: registers, mode and prefix gating, segment checks,
   guest exit bitmap and the thread segment swap on entry and exit.
   Assumes eig_consts.svh, eig_pkg and the design files are compiled ahead of it. */
`timescale 1ns/10ps
`include "eig_consts.svh"
module tb;
    logic              REF_CLK, RST, REG_WR, REG_RD, PROT_MODE, SMM_MODE, V86_MODE, PAGING_EN;
    logic              LONG_MODE, GUEST_MODE, CAP_LEAF_SET1, CAP_LAUNCH, INSN_VALID, INSN_SUPER;
    logic              PFX_OPSIZE, DS_USABLE, DS_EXP_DOWN, OTHER_BASE_NZ, ENCL_MODE64, ASYNC_EXIT;
    logic              SEG_WRITE_INSN, BASE_WR_INSN, BASE_WR_SEL, DONE, ADDR_WIDE, IN_ENCLAVE;
    logic              SEG_LOAD, AVAILABLE, KEY_PRESENT;
    logic [1:0]        PRIV_LEVEL;
    logic [2:0]        EXC_CODE;
    logic [3:0]        REG_ADDR;
    logic [5:0]        INSN_LEAF;
    logic [7:0]        DS_ATTR;
    logic [31:0]       REG_WDATA, REG_RDATA, DS_BASE, DS_LIMIT, ENCL_BASE, BASE_WR_DATA;
    logic [31:0]       SEG_A_OFS, SEG_A_LIM, SEG_B_OFS, SEG_B_LIM;
    eig_pkg::eig_seg_s CUR_SEG_A, CUR_SEG_B, SEG_A, SEG_B;
    int                error_cnt = 0;
    int                n_compared = 0;
    eig_gate dut (.REF_CLK(REF_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PROT_MODE(PROT_MODE),
        .SMM_MODE(SMM_MODE), .V86_MODE(V86_MODE), .PAGING_EN(PAGING_EN), .LONG_MODE(LONG_MODE),
        .GUEST_MODE(GUEST_MODE), .PRIV_LEVEL(PRIV_LEVEL), .CAP_LEAF_SET1(CAP_LEAF_SET1),
        .CAP_LAUNCH(CAP_LAUNCH), .INSN_VALID(INSN_VALID), .INSN_SUPER(INSN_SUPER),
        .INSN_LEAF(INSN_LEAF), .PFX_OPSIZE(PFX_OPSIZE), .DS_USABLE(DS_USABLE),
        .DS_EXP_DOWN(DS_EXP_DOWN), .DS_BASE(DS_BASE), .DS_LIMIT(DS_LIMIT), .DS_ATTR(DS_ATTR),
        .OTHER_BASE_NZ(OTHER_BASE_NZ), .ENCL_MODE64(ENCL_MODE64), .ENCL_BASE(ENCL_BASE),
        .SEG_A_OFS(SEG_A_OFS), .SEG_A_LIM(SEG_A_LIM), .SEG_B_OFS(SEG_B_OFS),
        .SEG_B_LIM(SEG_B_LIM), .CUR_SEG_A(CUR_SEG_A), .CUR_SEG_B(CUR_SEG_B),
        .ASYNC_EXIT(ASYNC_EXIT), .SEG_WRITE_INSN(SEG_WRITE_INSN), .BASE_WR_INSN(BASE_WR_INSN),
        .BASE_WR_SEL(BASE_WR_SEL), .BASE_WR_DATA(BASE_WR_DATA), .DONE(DONE),
        .EXC_CODE(EXC_CODE), .ADDR_WIDE(ADDR_WIDE), .IN_ENCLAVE(IN_ENCLAVE),
        .SEG_LOAD(SEG_LOAD), .SEG_A(SEG_A), .SEG_B(SEG_B), .AVAILABLE(AVAILABLE),
        .KEY_PRESENT(KEY_PRESENT));
    // ==========================================================
    // shared tasks
    task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        REG_WR    <= 1'b1;
        REG_ADDR  <= a;
        REG_WDATA <= d;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge REF_CLK);
        REG_RD   <= 1'b1;
        REG_ADDR <= a;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1 check("read data", REG_RDATA, exp);
    endtask
    // fault mask: one bit per environment condition that must stop the instruction
    task automatic env(input logic [8:0] f, input logic [1:0] priv, input logic guest);
        @(posedge REF_CLK);
        PROT_MODE     <= ~f[0];
        SMM_MODE      <= f[1];
        V86_MODE      <= f[2];
        PAGING_EN     <= ~f[3];
        PFX_OPSIZE    <= f[4];
        DS_USABLE     <= ~f[5];
        DS_EXP_DOWN   <= f[6];
        OTHER_BASE_NZ <= f[7];
        ENCL_MODE64   <= ~f[8];
        PRIV_LEVEL    <= priv;
        GUEST_MODE    <= guest;
    endtask
    task automatic insn(input logic sup, input logic [5:0] leaf, input logic [2:0] exp);
        @(posedge REF_CLK);
        INSN_VALID <= 1'b1;
        INSN_SUPER <= sup;
        INSN_LEAF  <= leaf;
        @(posedge REF_CLK);
        INSN_VALID <= 1'b0;
        #1 check("done", DONE, 1'b1);
        check("verdict", EXC_CODE, exp);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        env(9'h000, 2'd3, 1'b0);
        wr(`EIG_REG_FEAT_LO, 32'h0004_0000);
        insn(1'b0, `EIG_LEAF_ENTER, `EIG_EXC_UD);
        check("available", AVAILABLE, 1'b0);
        wr(`EIG_REG_KEY0, 32'h1234_5678);
        rd(`EIG_REG_KEY0, 32'h0000_0000);
        rd(`EIG_REG_CAPS, 32'h0000_0003);
        rd(4'h7, 32'h0000_0000);
        wr(`EIG_REG_FEAT_LO, 32'h0006_0001);
        wr(`EIG_REG_FEAT_LO, 32'h0000_0000);
        rd(`EIG_REG_FEAT_LO, 32'h0006_0001);
        check("available", AVAILABLE, 1'b1);
        wr(`EIG_REG_KEY0, 32'hbeef_0042);
        rd(`EIG_REG_KEY0, 32'hbeef_0042);
        @(posedge REF_CLK);
        CAP_LAUNCH <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        #1 check("key present", KEY_PRESENT, 1'b0);
        rd(`EIG_REG_KEY0, 32'h0000_0000);
        CAP_LAUNCH <= 1'b1;
    endtask
    task automatic t_gating();
        for (int i = 0; i < 11; i++) begin
            // one fault each for i 0 to 8, then two at once for i 9 and 10: the earlier check in the order must win
            env((i < 9) ? 9'(1 << i) : (i == 9) ? 9'h030 : 9'h048, 2'd3, 1'b0);
            insn(1'b0, `EIG_LEAF_ENTER, (i < 5 || i > 8) ? `EIG_EXC_UD : `EIG_EXC_GP0);
        end
        env(9'h000, 2'd2, 1'b0);
        insn(1'b0, `EIG_LEAF_ENTER, `EIG_EXC_GP0);
        env(9'h008, 2'd0, 1'b0);
        insn(1'b1, `EIG_LEAF_DBG_WR, `EIG_EXC_NONE);
        insn(1'b1, 6'h01, `EIG_EXC_UD);
    endtask
    task automatic t_guest();
        wr(`EIG_REG_BMAP_HI, 32'h0000_0100);
        wr(`EIG_REG_BMAP_LO, 32'h0000_0020);
        rd(`EIG_REG_BMAP_HI, 32'h0000_0100);
        wr(`EIG_REG_VMCTL, 32'h0000_0001);
        env(9'h000, 2'd0, 1'b1);
        insn(1'b1, 6'd40, `EIG_EXC_VMEXIT);
        insn(1'b1, 6'd5, `EIG_EXC_VMEXIT);
        insn(1'b1, 6'd41, `EIG_EXC_NONE);
        env(9'h000, 2'd3, 1'b1);
        insn(1'b1, 6'd40, `EIG_EXC_GP0);
        wr(`EIG_REG_VMCTL, 32'h0000_0000);
        env(9'h000, 2'd0, 1'b1);
        insn(1'b1, 6'd40, `EIG_EXC_NONE);
    endtask
    task automatic t_entry();
        env(9'h000, 2'd3, 1'b0);
        insn(1'b0, `EIG_LEAF_ENTER, `EIG_EXC_NONE);
        check("load", SEG_LOAD, 1'b1);
        check("seg a", SEG_A[71:8], {32'h0010_2000, 32'h0000_0fff});
        check("seg b", SEG_B[71:8], {32'h0010_3000, 32'h0000_07ff});
        check("wide", ADDR_WIDE, 1'b1);
        @(posedge REF_CLK);
        SEG_WRITE_INSN <= 1'b1;
        CUR_SEG_A      <= '{32'h0010_2000, 32'h0000_0fff, 8'h93};
        @(posedge REF_CLK);
        SEG_WRITE_INSN <= 1'b0;
        #1 check("seg write", {DONE, EXC_CODE}, {1'b1, `EIG_EXC_UD});
        @(posedge REF_CLK);
        BASE_WR_INSN <= 1'b1;
        @(posedge REF_CLK);
        BASE_WR_INSN <= 1'b0;
        ASYNC_EXIT   <= 1'b1;
        @(posedge REF_CLK);
        ASYNC_EXIT <= 1'b0;
        CUR_SEG_A  <= '{32'h0000_a000, 32'h0000_0fff, 8'h93};
        #1 check("async restore", SEG_A, {32'h0000_a000, 32'h0000_0fff, 8'h93});
        insn(1'b0, `EIG_LEAF_RESUME, `EIG_EXC_NONE);
        check("resume base", SEG_A.base, 32'h0050_0000);
        rd(`EIG_REG_STATUS, 32'h0000_0007);
        @(posedge REF_CLK);
        LONG_MODE <= 1'b0;
        insn(1'b0, `EIG_LEAF_EXIT, `EIG_EXC_NONE);
        check("exit restore", {SEG_LOAD, SEG_A}, {1'b1, 72'h0000_a000_0000_0fff_93});
        check("narrow", {ADDR_WIDE, IN_ENCLAVE}, 2'b00);
    endtask
    // ==========================================================
    // clock, stimulus, watchdog
    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end
    initial begin
        {REG_WR, REG_RD, INSN_VALID, INSN_SUPER, ASYNC_EXIT, SEG_WRITE_INSN} = '0;
        {BASE_WR_INSN, BASE_WR_SEL, SMM_MODE, V86_MODE, PFX_OPSIZE, DS_EXP_DOWN} = '0;
        {OTHER_BASE_NZ, GUEST_MODE, REG_ADDR, REG_WDATA, INSN_LEAF, DS_BASE} = '0;
        {PROT_MODE, PAGING_EN, LONG_MODE, ENCL_MODE64, DS_USABLE} = '1;
        {CAP_LEAF_SET1, CAP_LAUNCH, PRIV_LEVEL, DS_LIMIT, DS_ATTR} = {4'hf, 32'hffff_ffff, 8'hf3};
        {ENCL_BASE, SEG_A_OFS, SEG_B_OFS} = {32'h0010_0000, 32'h0000_2000, 32'h0000_3000};
        {SEG_A_LIM, SEG_B_LIM, BASE_WR_DATA} = {32'h0000_0fff, 32'h0000_07ff, 32'h0050_0000};
        CUR_SEG_A = '{32'h0000_a000, 32'h0000_0fff, 8'h93};
        CUR_SEG_B = '{32'h0000_b000, 32'h0000_0fff, 8'h93};
        RST       = 1'b1;
        repeat (10) @(posedge REF_CLK);
        RST <= 1'b0;
        t_regs();
        t_gating();
        t_guest();
        t_entry();
        tally_and_finish();
    end
    initial begin
        #100us;
        error_cnt++;
        tally_and_finish();
    end
endmodule
